// ==== include/gioc_defines.svh ====
`ifndef GIOC_DEFINES_SVH
`define GIOC_DEFINES_SVH

// register byte addresses on the AXI4-Lite port
`define GIOC_ADDR_W     4
`define GIOC_CFG_ADDR   4'h0
`define GIOC_CTRL_ADDR  4'h4
`define GIOC_STAT_ADDR  4'h8

// configuration word layout
`define GIOC_CFG_W      17
`define GIOC_CFG_RST    17'h00001
`define GIOC_MODE_LSB   0
`define GIOC_MODE_MSB   5
`define GIOC_IN_REG     6
`define GIOC_IN_NEG     7
`define GIOC_OUT_REG    8
`define GIOC_OUT_NEG    9
`define GIOC_OE_REG     10
`define GIOC_OE_NEG     11
`define GIOC_OUT_INV    12
`define GIOC_DUAL_EDGE_IO_IN    13
`define GIOC_DUAL_EDGE_IO_OUT   14
`define GIOC_RESYNC     15
`define GIOC_PULL_DN    16

// control word
`define GIOC_USER_BIT   0

// bus responses
`define GIOC_RESP_OKAY  2'h0
`define GIOC_RESP_SLV   2'h2

`endif

// ==== include/gioc_pkg.sv ====
package gioc_pkg;

  // pin modes, one-hot as stored in the configuration word
  typedef enum logic [5:0] {
    mode_unused = 6'h01,
    mode_input  = 6'h02,
    mode_alt    = 6'h04,
    mode_output = 6'h08,
    mode_bidir  = 6'h10,
    mode_clkout = 6'h20
  } gioc_mode_type;

endpackage

// ==== rtl/gioc_edge_reg.sv ====
`timescale 1ns/1ps
`default_nettype none

// pair of flops, one on each clock edge; caller picks or muxes them
module gioc_edge_reg #(
  parameter int W = 1
) (
  input  wire logic         aclk,    // core clock
  input  wire logic         aresetn, // sync reset, active low
  input  wire logic [W-1:0] d_rise,  // data taken on rising edge
  input  wire logic [W-1:0] d_fall,  // data taken on falling edge
  output logic      [W-1:0] q_rise,  // rising-edge sample
  output logic      [W-1:0] q_fall   // falling-edge sample
);

  logic [W-1:0] rise_nxt;
  logic [W-1:0] fall_nxt;

  // next values
  always_comb begin
    rise_nxt = d_rise;
    fall_nxt = d_fall;
  end

  // rising-edge flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_rise <= '0;
    end else begin
      q_rise <= rise_nxt;
    end
  end

  // falling-edge flop; reset still sampled, only on the other edge
  always_ff @(negedge aclk) begin
    if (!aresetn) begin
      q_fall <= '0;
    end else begin
      q_fall <= fall_nxt;
    end
  end

endmodule // gioc_edge_reg

`default_nettype wire

// ==== rtl/gioc_cell.sv ====
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gioc_defines.svh"

module gioc_cell #(
  parameter bit DIFF_PIN = 1'b0 // differential-capable pin used single ended
) (
  input  wire logic                    aclk,          // core clock
  input  wire logic                    aresetn,       // sync reset, low
  input  wire logic [`GIOC_ADDR_W-1:0] s_axi_awaddr,  // write address
  input  wire logic                    s_axi_awvalid, // write address valid
  output logic                         s_axi_awready, // write address ready
  input  wire logic [31:0]             s_axi_wdata,   // write data
  input  wire logic [3:0]              s_axi_wstrb,   // byte strobes
  input  wire logic                    s_axi_wvalid,  // write data valid
  output logic                         s_axi_wready,  // write data ready
  output logic      [1:0]              s_axi_bresp,   // write response
  output logic                         s_axi_bvalid,  // response valid
  input  wire logic                    s_axi_bready,  // response ready
  input  wire logic [`GIOC_ADDR_W-1:0] s_axi_araddr,  // read address
  input  wire logic                    s_axi_arvalid, // read address valid
  output logic                         s_axi_arready, // read address ready
  output logic      [31:0]             s_axi_rdata,   // read data
  output logic      [1:0]              s_axi_rresp,   // read response
  output logic                         s_axi_rvalid,  // read data valid
  input  wire logic                    s_axi_rready,  // read data ready
  input  wire logic [1:0]              core_out,      // core data to pad
  input  wire logic                    core_oe,       // core output enable
  output logic      [1:0]              core_in,       // pad data to core
  output logic                         alternate_input_path, // to other block
  input  wire logic                    pad_i,         // pad level in
  output logic                         pad_o,         // pad level out
  output logic                         pad_oe,        // pad driven when high
  output logic                         pull_up_en,    // weak pull-up on
  output logic                         pull_down_en   // weak pull-down on
);

  // ---------------- configuration and bus state ----------------
  logic [`GIOC_CFG_W-1:0]  cfg_r, cfg_nxt;
  logic                    user_mode_r, user_mode_nxt;
  logic                    aw_hold_r, aw_hold_nxt;
  logic [`GIOC_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic                    w_hold_r, w_hold_nxt;
  logic [31:0]             w_data_r, w_data_nxt;
  logic [3:0]              w_strb_r, w_strb_nxt;
  logic                    bvalid_r, bvalid_nxt;
  logic [1:0]              bresp_r, bresp_nxt;
  logic                    rvalid_r, rvalid_nxt;
  logic [31:0]             rdata_r, rdata_nxt;
  logic [1:0]              rresp_r, rresp_nxt;
  logic [31:0]             wmask;

  // ---------------- pin-side state ----------------
  logic pad_s1_r, pad_s1_nxt;
  logic pad_s, pad_s_nxt;
  logic in1_rs_r, in1_rs_nxt;
  logic out1_rs_r, out1_rs_nxt;
  logic pull_up_r, pull_up_nxt;
  logic pull_down_r, pull_down_nxt;
  logic in_q_rise, in_q_fall;
  logic out_q_rise, out_q_fall, out_d_rise, out_d_fall;
  logic oe_q_rise, oe_q_fall;
  logic out_val, oe_val;

  // decoded configuration
  gioc_pkg::gioc_mode_type mode;
  logic in_en, out_en, alt_en, clk_en, unused;
  logic in_reg, in_neg, out_reg, out_neg, oe_reg, oe_neg;
  logic out_inv, dual_edge_io_in, dual_edge_io_out, resync, pull_dn;

  assign mode = gioc_pkg::gioc_mode_type'(
                  cfg_r[`GIOC_MODE_MSB:`GIOC_MODE_LSB]);
  assign in_reg   = cfg_r[`GIOC_IN_REG];
  assign in_neg   = cfg_r[`GIOC_IN_NEG];
  assign out_reg  = cfg_r[`GIOC_OUT_REG];
  assign out_neg  = cfg_r[`GIOC_OUT_NEG];
  assign oe_reg   = cfg_r[`GIOC_OE_REG];
  assign oe_neg   = cfg_r[`GIOC_OE_NEG];
  assign out_inv  = cfg_r[`GIOC_OUT_INV];
  assign dual_edge_io_in  = cfg_r[`GIOC_DUAL_EDGE_IO_IN];
  assign dual_edge_io_out = cfg_r[`GIOC_DUAL_EDGE_IO_OUT];
  assign resync   = cfg_r[`GIOC_RESYNC];
  assign pull_dn  = cfg_r[`GIOC_PULL_DN];

  // path enables per mode; bad codes fall back to unused
  always_comb begin
    in_en  = 1'b0;
    out_en = 1'b0;
    alt_en = 1'b0;
    clk_en = 1'b0;
    unused = 1'b0;
    case (mode)
      gioc_pkg::mode_input:  in_en  = 1'b1;
      gioc_pkg::mode_alt:    alt_en = 1'b1;
      gioc_pkg::mode_output: out_en = 1'b1;
      gioc_pkg::mode_bidir: begin
        in_en  = 1'b1;
        out_en = 1'b1;
      end
      gioc_pkg::mode_clkout: clk_en = 1'b1;
      default:               unused = 1'b1;
    endcase
  end

  // ---------------- AXI4-Lite slave ----------------
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                  {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // write side: address and data in either order, commit once both held
  always_comb begin
    cfg_nxt       = cfg_r;
    user_mode_nxt = user_mode_r;
    aw_hold_nxt   = aw_hold_r;
    aw_addr_nxt   = aw_addr_r;
    w_hold_nxt    = w_hold_r;
    w_data_nxt    = w_data_r;
    w_strb_nxt    = w_strb_r;
    bvalid_nxt    = bvalid_r;
    bresp_nxt     = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_hold_r && w_hold_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `GIOC_RESP_OKAY;
      case (aw_addr_r)
        `GIOC_CFG_ADDR: begin
          // frozen in user mode so the paths never change under traffic
          if (!user_mode_r) begin
            cfg_nxt = (cfg_r & ~wmask[`GIOC_CFG_W-1:0]) |
                      (w_data_r[`GIOC_CFG_W-1:0] & wmask[`GIOC_CFG_W-1:0]);
          end
        end
        `GIOC_CTRL_ADDR: begin
          if (w_strb_r[0]) begin
            user_mode_nxt = w_data_r[`GIOC_USER_BIT];
          end
        end
        `GIOC_STAT_ADDR: ; // read only, write ignored
        default: bresp_nxt = `GIOC_RESP_SLV;
      endcase
    end
  end

  // read side: one read in flight, data one edge after the address
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `GIOC_RESP_OKAY;
      case (s_axi_araddr)
        `GIOC_CFG_ADDR:
          rdata_nxt = {{(32-`GIOC_CFG_W){1'b0}}, cfg_r};
        `GIOC_CTRL_ADDR:
          rdata_nxt = {31'h0, user_mode_r};
        `GIOC_STAT_ADDR:
          rdata_nxt = {27'h0, user_mode_r, pad_oe, core_in, pad_s};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = `GIOC_RESP_SLV;
        end
      endcase
    end
  end

  // register and bus flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r       <= `GIOC_CFG_RST;
      user_mode_r <= 1'b0;
      aw_hold_r   <= 1'b0;
      aw_addr_r   <= '0;
      w_hold_r    <= 1'b0;
      w_data_r    <= 32'h0;
      w_strb_r    <= 4'h0;
      bvalid_r    <= 1'b0;
      bresp_r     <= `GIOC_RESP_OKAY;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h0;
      rresp_r     <= `GIOC_RESP_OKAY;
    end else begin
      cfg_r       <= cfg_nxt;
      user_mode_r <= user_mode_nxt;
      aw_hold_r   <= aw_hold_nxt;
      aw_addr_r   <= aw_addr_nxt;
      w_hold_r    <= w_hold_nxt;
      w_data_r    <= w_data_nxt;
      w_strb_r    <= w_strb_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      rvalid_r    <= rvalid_nxt;
      rdata_r     <= rdata_nxt;
      rresp_r     <= rresp_nxt;
    end
  end

  // ---------------- pin logic ----------------
  // pad sync, resync copies and pull control
  always_comb begin
    pad_s1_nxt  = pad_i;
    pad_s_nxt   = pad_s1_r;
    in1_rs_nxt  = in_q_fall;
    out1_rs_nxt = core_out[1];
    pull_up_nxt   = 1'b0;
    pull_down_nxt = 1'b0;
    if (!user_mode_r) begin
      pull_up_nxt = !DIFF_PIN;
    end else if (unused) begin
      // with pull_dn clear on a single-ended pin, pull-up stays asserted through the switch: no glitch
      pull_up_nxt   = !pull_dn;
      pull_down_nxt = pull_dn && !DIFF_PIN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_s1_r    <= 1'b0;
      pad_s       <= 1'b0;
      in1_rs_r    <= 1'b0;
      out1_rs_r   <= 1'b0;
      pull_up_r   <= !DIFF_PIN; // differential-capable pins float in reset
      pull_down_r <= 1'b0;
    end else begin
      pad_s1_r    <= pad_s1_nxt;
      pad_s       <= pad_s_nxt;
      in1_rs_r    <= in1_rs_nxt;
      out1_rs_r   <= out1_rs_nxt;
      pull_up_r   <= pull_up_nxt;
      pull_down_r <= pull_down_nxt;
    end
  end

  assign pull_up_en   = pull_up_r;
  assign pull_down_en = pull_down_r;

  // input register pair, both edges always sampled
  gioc_edge_reg #(.W(1)) u_in_reg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_rise  (pad_s),
    .d_fall  (pad_s),
    .q_rise  (in_q_rise),
    .q_fall  (in_q_fall)
  );

  // core-facing input data; in dual-edge mode bit 0 rising, bit 1 falling
  always_comb begin
    core_in = 2'h0;
    if (in_en) begin
      if (dual_edge_io_in) begin
        core_in = {resync ? in1_rs_r : in_q_fall, in_q_rise};
      end else if (in_reg) begin
        core_in = {1'b0, in_neg ? in_q_fall : in_q_rise};
      end else begin
        core_in = {1'b0, pad_s};
      end
    end
  end

  // alternate path: no register on offer, never reaches core_in
  assign alternate_input_path = alt_en ? pad_s : 1'b0;

  // output launch data; clock-out forwards 1 on high, 0 on low phase
  always_comb begin
    out_d_rise = core_out[0];
    out_d_fall = core_out[0];
    if (clk_en) begin
      out_d_rise = 1'b1;
      out_d_fall = 1'b0;
    end else if (dual_edge_io_out) begin
      out_d_fall = resync ? out1_rs_r : core_out[1];
    end
  end

  gioc_edge_reg #(.W(1)) u_out_reg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_rise  (out_d_rise),
    .d_fall  (out_d_fall),
    .q_rise  (out_q_rise),
    .q_fall  (out_q_fall)
  );

  gioc_edge_reg #(.W(1)) u_oe_reg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_rise  (core_oe),
    .d_fall  (core_oe),
    .q_rise  (oe_q_rise),
    .q_fall  (oe_q_fall)
  );

  // pad value; the clock mux costs a half-cycle of hold margin
  always_comb begin
    out_val = core_out[0];
    if (clk_en) begin
      out_val = aclk ? out_q_rise : out_q_fall;
    end else if (dual_edge_io_out) begin
      out_val = (aclk ? out_q_rise : out_q_fall) ^ out_inv;
    end else if (out_reg) begin
      out_val = (out_neg ? out_q_fall : out_q_rise) ^ out_inv;
    end
  end

  // buffer enable: direct, or registered on the edge that oe_neg picks
  assign oe_val = oe_reg ? (oe_neg ? oe_q_fall : oe_q_rise)
                         : core_oe;
  assign pad_oe = user_mode_r && (clk_en || (out_en && oe_val));
  assign pad_o  = pad_oe ? out_val : 1'b0;

  // ---------------- assertions ----------------
  sequence s_enter_pullup;
    $rose(user_mode_r) && unused && !pull_dn && !DIFF_PIN;
  endsequence

  a_cfg_static: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(user_mode_r) && user_mode_r |-> $stable(cfg_r))
    else $error("configuration changed in user mode");

  a_config_pulls: assert property (@(posedge aclk) disable iff (!aresetn)
    !user_mode_r ##1 1'b1 |-> pull_up_r == !DIFF_PIN && !pull_down_r)
    else $error("wrong pulls during configuration");

  a_config_float: assert property (@(posedge aclk) disable iff (!aresetn)
    !user_mode_r |-> !pad_oe)
    else $error("pad driven during configuration");

  a_unused_pull: assert property (@(posedge aclk) disable iff (!aresetn)
    user_mode_r && unused ##1 user_mode_r |->
      pull_up_r == !$past(pull_dn) && !pad_oe)
    else $error("unused pin pull wrong");

  a_pullup_steady: assert property (@(posedge aclk) disable iff (!aresetn)
    s_enter_pullup |-> pull_up_r [*3])
    else $error("pull-up dropped entering user mode");

  a_in_reg_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    user_mode_r && in_en && in_reg && !in_neg && !dual_edge_io_in ##1 user_mode_r
      |-> core_in[0] == $past(pad_s))
    else $error("registered input not one cycle behind pad");

  a_resync_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    user_mode_r && in_en && dual_edge_io_in && resync ##1 user_mode_r
      |-> core_in == {2{$past(pad_s)}})
    else $error("resync pair misaligned");

  a_oe_reg: assert property (@(posedge aclk) disable iff (!aresetn)
    user_mode_r && out_en && oe_reg && !oe_neg ##1 user_mode_r
      |-> pad_oe == $past(core_oe))
    else $error("registered enable not one cycle behind core");

  a_alt_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    alt_en |-> core_in == 2'h0 && !pad_oe)
    else $error("alternate input leaked into core path");

endmodule // gioc_cell

`default_nettype wire

// ==== tb/gioc_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// outside circuit on the pad: one external driver plus the weak pulls
module gioc_pad_model (
  input  wire logic aclk,         // bench clock, paces the float pattern
  input  wire logic pad_o,        // level the cell drives
  input  wire logic pad_oe,       // cell drives the pad
  input  wire logic pull_up_en,   // weak pull-up on
  input  wire logic pull_down_en, // weak pull-down on
  input  wire logic ext_en,       // external driver active
  input  wire logic ext_val,      // external driver level
  output logic      pad_i         // resolved pad level
);
  logic flt_r = 1'b0; // a floating pad must never look like a steady level

  always @(posedge aclk) flt_r <= ~flt_r;

  // cell driver first, then the outside driver, then the pulls
  always_comb begin
    if (pad_oe) pad_i = pad_o;
    else if (ext_en) pad_i = ext_val;
    else if (pull_up_en) pad_i = 1'b1;
    else if (pull_down_en) pad_i = 1'b0;
    else pad_i = flt_r;
  end
endmodule // gioc_pad_model

`default_nettype wire

// ==== tb/tb_gpio_io_logic_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gioc_defines.svh"

module tb_gpio_io_logic_cell;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, core_oe, alt_o;
  logic        pad_i, pad_o, pad_oe, pu, pd, ext_en, ext_val, watch;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs, core_out, core_in;
  int          n_errors, compares, cycles, glitches;
  localparam logic [1:0]  OK = `GIOC_RESP_OKAY;
  localparam logic [1:0]  SE = `GIOC_RESP_SLV;
  localparam logic [16:0] F_IR = 17'h00001 << `GIOC_IN_REG;
  localparam logic [16:0] F_IN = 17'h00001 << `GIOC_IN_NEG;
  localparam logic [16:0] F_OR = 17'h00001 << `GIOC_OUT_REG;
  localparam logic [16:0] F_ON = 17'h00001 << `GIOC_OUT_NEG;
  localparam logic [16:0] F_ER = 17'h00001 << `GIOC_OE_REG;
  localparam logic [16:0] F_EN = 17'h00001 << `GIOC_OE_NEG;
  localparam logic [16:0] F_IV = 17'h00001 << `GIOC_OUT_INV;
  localparam logic [16:0] F_DI = 17'h00001 << `GIOC_DUAL_EDGE_IO_IN;
  localparam logic [16:0] F_DO = 17'h00001 << `GIOC_DUAL_EDGE_IO_OUT;
  localparam logic [16:0] F_RS = 17'h00001 << `GIOC_RESYNC;
  localparam logic [16:0] F_PD = 17'h00001 << `GIOC_PULL_DN;

  gioc_cell i_gioc_cell (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_out(core_out),
    .core_oe(core_oe), .core_in(core_in), .alternate_input_path(alt_o),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .pull_up_en(pu),
    .pull_down_en(pd));

  gioc_pad_model i_gioc_pad_model (.aclk(aclk), .pad_o(pad_o),
    .pad_oe(pad_oe), .pull_up_en(pu), .pull_down_en(pd), .ext_en(ext_en),
    .ext_val(ext_val), .pad_i(pad_i));

  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_errors++;
      final_report();
    end
  end

  // any edge on the pull-up while watched is a glitch
  always @(pu) if (watch) glitches++;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // aw and w offered together, each released once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // ends on the first bvalid; if none comes, only the hang guard ends this wait
    while (!b) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        b = 1'b1;
        bready <= 1'b0;
        chk("bresp", bresp, er);
        chk("wr_busy", {awready, wready}, 2'b00);
      end
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        b = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        chk("rd_busy", arready, 1'b0);
      end
    end
  endtask

  task automatic rst();
    @(posedge aclk);
    aresetn  <= 1'b0;
    core_oe  <= 1'b0;
    core_out <= 2'h0;
    ext_en   <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // configuration must be in place before user mode is entered
  task automatic setup(input gioc_pkg::gioc_mode_type m,
                       input logic [16:0] f);
    rst();
    axi_wr(`GIOC_CFG_ADDR, {15'h0000, f | {11'h000, m}}, OK);
    axi_wr(`GIOC_CTRL_ADDR, 32'h00000001, OK);
    repeat (4) @(posedge aclk);
  endtask

  task automatic drive_pad(input logic v);
    @(posedge aclk);
    ext_en  <= 1'b1;
    ext_val <= v;
    repeat (5) @(posedge aclk);
    #1;
  endtask

  task automatic t_reset();
    rst();
    @(posedge aclk);
    #1;
    chk("pull_up", pu, 1'b1);
    chk("pull_dn", pd, 1'b0);
    chk("pad_oe", pad_oe, 1'b0);
    axi_rd(`GIOC_CFG_ADDR, rd, rs);
    chk("cfg", rd, 32'(`GIOC_CFG_RST));
    axi_rd(`GIOC_CTRL_ADDR, rd, rs);
    chk("ctrl", rd, 32'h00000000);
  endtask

  task automatic t_regs();
    axi_wr(`GIOC_CFG_ADDR, 32'h00012345, OK);
    axi_wr(4'hC, 32'h00000001, SE);
    axi_wr(4'h2, 32'h00000001, SE);
    axi_wr(`GIOC_STAT_ADDR, 32'hFFFFFFFF, OK);
    axi_rd(4'hC, rd, rs);
    chk("unmapped_rd", {rs, rd[29:0]}, {SE, 30'h00000000});
    axi_wr(`GIOC_CTRL_ADDR, 32'h00000001, OK);
    axi_wr(`GIOC_CFG_ADDR, 32'h00000001, OK);
    axi_rd(`GIOC_CFG_ADDR, rd, rs);
    chk("cfg_locked", rd, 32'h00012345);
    axi_rd(`GIOC_STAT_ADDR, rd, rs);
    chk("stat_user", rd[4], 1'b1);
  endtask

  task automatic t_unused();
    rst();
    watch = 1'b1;
    axi_wr(`GIOC_CTRL_ADDR, 32'h00000001, OK);
    repeat (3) @(posedge aclk);
    #1;
    watch = 1'b0;
    chk("glitches", glitches, 0);
    chk("unused_pu", {pu, pd, pad_oe}, 3'b100);
    setup(gioc_pkg::mode_unused, F_PD);
    #1;
    chk("unused_pd", {pu, pd, pad_oe}, 3'b010);
  endtask

  task automatic t_input();
    logic [16:0] f[3] = '{17'h00000, F_IR, F_IR | F_IN};
    for (int r = 0; r < 3; r++) begin
      setup(gioc_pkg::mode_input, f[r]);
      for (int v = 1; v >= 0; v--) begin
        drive_pad(v[0]);
        chk("in_core", core_in[0], v[0]);
        chk("in_oe", pad_oe, 1'b0);
      end
    end
    setup(gioc_pkg::mode_alt, 17'h00000);
    for (int v = 1; v >= 0; v--) begin
      drive_pad(v[0]);
      chk("alt", {alt_o, pad_oe}, {v[0], 1'b0});
    end
  endtask

  task automatic t_output();
    logic [16:0] f[3] = '{17'h00000, F_OR | F_ER | F_IV,
                          F_OR | F_ON | F_ER | F_EN | F_IV};
    for (int r = 0; r < 3; r++) begin
      setup(gioc_pkg::mode_output, f[r]);
      for (int v = 0; v < 2; v++) begin
        @(posedge aclk);
        core_out <= {1'b0, v[0]};
        core_oe  <= 1'b1;
        repeat (3) @(posedge aclk);
        #1;
        chk("out_pad", {pad_oe, pad_o}, {1'b1, v[0] ^ (r > 0)});
        @(posedge aclk);
        core_oe <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
        chk("out_off", pad_oe, 1'b0);
      end
    end
  endtask

  task automatic t_bidir();
    setup(gioc_pkg::mode_bidir, F_IR | F_OR | F_ON | F_ER);
    for (int v = 0; v < 2; v++) begin
      @(posedge aclk);
      core_out <= {1'b0, v[0]};
      core_oe  <= 1'b1;
      repeat (6) @(posedge aclk);
      #1;
      chk("bidir_loop", {pad_o, core_in[0]}, {2{v[0]}});
    end
    @(posedge aclk);
    core_oe <= 1'b0;
    drive_pad(1'b0);
    chk("bidir_in", {pad_oe, core_in[0]}, 2'b00);
  endtask

  task automatic t_dual_edge_io();
    for (int r = 0; r < 2; r++) begin
      setup(gioc_pkg::mode_input, F_IR | F_DI | (r ? F_RS : 17'h00000));
      for (int v = 0; v < 2; v++) begin
        drive_pad(v[0]);
        chk("dual_edge_io_in", core_in, {2{v[0]}});
      end
      setup(gioc_pkg::mode_output, F_OR | F_ER | F_DO | (r ? F_RS : 17'h00000));
      for (int p = 1; p < 3; p++) begin
        @(posedge aclk);
        core_out <= p[1:0];
        core_oe  <= 1'b1;
        repeat (4) @(posedge aclk);
        #2;
        chk("dual_edge_io_hi", pad_o, p[0]);
        #5;
        chk("dual_edge_io_lo", pad_o, p[1]);
      end
    end
    setup(gioc_pkg::mode_clkout, 17'h00000);
    @(posedge aclk);
    #2;
    chk("clk_hi", {pad_oe, pad_o}, 2'b11);
    #5;
    chk("clk_lo", pad_o, 1'b0);
  endtask

  // every input defined at time zero, reset held from the start
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, core_oe} = 6'h00;
    {ext_en, ext_val, watch} = 3'h0;
    {awaddr, araddr, wdata, core_out} = 42'h0;
    wstrb = 4'hF;
    {n_errors, compares, cycles, glitches} = {4{32'h0}};
    t_reset();
    t_regs();
    t_unused();
    t_input();
    t_output();
    t_bidir();
    t_dual_edge_io();
    final_report();
  end
endmodule // tb_gpio_io_logic_cell

`default_nettype wire
